// ===== rail_seq_pkg.sv
// Constants and types for the rail sequencing and group event block.
// Assumes a decoded command port (code, write, write data) from a bus front end.
// How it works
// (R1) Output enables only when enable state active and predecessor reported power-good.
// (R2) Output disables after programmed delay once follower reports power-down.
// (R3) Order register bits 12:8 hold predecessor rail id 0-31.
// (R4) Order register bits 4:0 hold follower rail id 0-31.
// (R5) Order bit 15 set makes the predecessor wait apply.
// (R6) Order bit 7 set makes the follower dependency apply.
// (R7) Loop register: bit 24 enable, 23:16 residual, 15:0 gain.
// (R8) Tracking bit 7 enables voltage tracking.
// (R9) Tracking bit 2 selects 100 or 50 percent of reference.
// (R10) Tracking bit 1 selects target or reference pin as upper limit.
// (R11) Group bits 20:16 id sent with setpoint broadcasts.
// (R12) Group bit 21 set applies setpoint broadcasts with matching id.
// (R13) Group bits 12:8 id sent with operation broadcasts.
// (R14) Group bit 13 set answers operation broadcasts with matching id.
// (R15) Group bits 4:0 id sent with power-fail broadcasts.
// (R16) Matching power-fail: bit 5 low sequenced, high immediate shutdown.
// (R17) Current-sharing phases follow power-fail events regardless of group.
// (R18) Host places all current-sharing rails in one common group.
// (R19) Device emits its own power-good and power-down events with its id; power-down only on leaving the stop delay.
package rail_seq_pkg;
  localparam logic [7:0] LOOP_RESP_OFS = 8'hdf;
  localparam logic [7:0] RAIL_ORDER_OFS = 8'he0;
  localparam logic [7:0] TRACK_OFS = 8'he1;
  localparam logic [7:0] GROUP_OFS = 8'he2;
  localparam int LOOP_EN_BIT = 24;
  localparam int RESID_LSB = 16;
  localparam int GAIN_LSB = 0;
  localparam int PRE_EN_BIT = 15;
  localparam int PRE_ID_LSB = 8;
  localparam int FOL_EN_BIT = 7;
  localparam int FOL_ID_LSB = 0;
  localparam int TRK_EN_BIT = 7;
  localparam int TRK_RATIO_BIT = 2;
  localparam int TRK_LIMIT_BIT = 1;
  localparam int VSET_RESP_BIT = 21;
  localparam int VSET_ID_LSB = 16;
  localparam int OPER_RESP_BIT = 13;
  localparam int OPER_ID_LSB = 8;
  localparam int PFAIL_RESP_BIT = 5;
  localparam int PFAIL_ID_LSB = 0;
  localparam logic [31:0] LOOP_RESP_RST = 32'h0000_0000;
  localparam logic [15:0] RAIL_ORDER_RST = 16'h0000;
  localparam logic [7:0] TRACK_RST = 8'h00;
  localparam logic [31:0] GROUP_RST = 32'h0000_0000;
  localparam logic [31:0] GROUP_WMASK = 32'h003f_3f3f;
  localparam logic [31:0] LOOP_WMASK = 32'h01ff_ffff;
  localparam logic [15:0] ORDER_WMASK = 16'h9f9f;
  localparam logic [7:0] TRACK_WMASK = 8'h86;
  // Group bus event kinds
  typedef enum logic [2:0] {
    EV_POWER_GOOD = 3'h0,
    EV_POWER_DOWN = 3'h1,
    EV_POWER_FAIL = 3'h2,
    EV_OPERATION = 3'h3,
    EV_VSETPOINT = 3'h4
  } event_kind_t;
  typedef enum logic [3:0] {
    ST_OFF = 4'b0001,
    ST_WAIT_PRE = 4'b0010,
    ST_ON = 4'b0100,
    ST_STOP_DLY = 4'b1000
  } seq_state_t;
endpackage

// ===== group_event_if.sv
// Carries one group bus event between the sequencer and the event matcher.
// Assumes both ends share sys_clk_i.
`timescale 1ns/1ps
interface group_event_if;
  logic valid;
  rail_seq_pkg::event_kind_t kind;
  logic [4:0] id;
  logic pgood_pre;
  logic pdown_fol;
  logic pfail_seq;
  logic pfail_imm;
  logic oper_hit;
  logic oper_on;
  logic vset_hit;
  modport matcher (input valid, kind, id, output pgood_pre, pdown_fol,
    pfail_seq, pfail_imm, oper_hit, oper_on, vset_hit);
  modport user (output valid, kind, id, input pgood_pre, pdown_fol,
    pfail_seq, pfail_imm, oper_hit, oper_on, vset_hit);
endinterface

// ===== group_event_match.sv
// Decodes received group bus events against the order and group settings.
// Pure combinational; the sequencer registers what it needs.
`timescale 1ns/1ps
module group_event_match (
  input wire logic [15:0] order_i,
  input wire logic [31:0] group_i,
  input wire logic share_phase_i,
  input wire logic oper_data_i,
  group_event_if.matcher ev
);
  logic [4:0] pre_id;
  logic [4:0] fol_id;
  logic [4:0] pf_id;
  logic [4:0] op_id;
  logic [4:0] vs_id;
  logic pf_match;
  assign pre_id = order_i[rail_seq_pkg::PRE_ID_LSB +: 5]; // [R3]
  assign fol_id = order_i[rail_seq_pkg::FOL_ID_LSB +: 5]; // [R4]
  assign pf_id = group_i[rail_seq_pkg::PFAIL_ID_LSB +: 5];
  assign op_id = group_i[rail_seq_pkg::OPER_ID_LSB +: 5];
  assign vs_id = group_i[rail_seq_pkg::VSET_ID_LSB +: 5];
  // Sharing phases take every power fail, whatever the group id
  assign pf_match = ev.valid && ev.kind == rail_seq_pkg::EV_POWER_FAIL &&
    (share_phase_i || ev.id == pf_id); // [R17]
  assign ev.pgood_pre = ev.valid && ev.kind == rail_seq_pkg::EV_POWER_GOOD &&
    order_i[rail_seq_pkg::PRE_EN_BIT] && ev.id == pre_id; // [R5]
  assign ev.pdown_fol = ev.valid && ev.kind == rail_seq_pkg::EV_POWER_DOWN &&
    order_i[rail_seq_pkg::FOL_EN_BIT] && ev.id == fol_id; // [R6]
  assign ev.pfail_seq = pf_match &&
    !group_i[rail_seq_pkg::PFAIL_RESP_BIT]; // [R16]
  assign ev.pfail_imm = pf_match &&
    group_i[rail_seq_pkg::PFAIL_RESP_BIT]; // [R16]
  assign ev.oper_hit = ev.valid && ev.kind == rail_seq_pkg::EV_OPERATION &&
    group_i[rail_seq_pkg::OPER_RESP_BIT] && ev.id == op_id; // [R14]
  assign ev.oper_on = oper_data_i;
  assign ev.vset_hit = ev.valid && ev.kind == rail_seq_pkg::EV_VSETPOINT &&
    group_i[rail_seq_pkg::VSET_RESP_BIT] && ev.id == vs_id; // [R12]
endmodule // group_event_match

// ===== rail_sequence_group_control.sv
// Rail start/stop sequencer with command registers and group bus events.
// Assumes a decoded command port and an event framer outside this block.
`timescale 1ns/1ps
module rail_sequence_group_control #(
  parameter int DELAY_W = 16
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // Command port
  input wire logic [7:0] cmd_code_i,
  input wire logic cmd_wr_i,
  input wire logic [31:0] cmd_wdata_i,
  output logic [31:0] cmd_rdata_o,
  output logic cmd_ack_o,
  output logic cmd_hit_o,
  // Enable sources
  input wire logic ctrl_en_i,
  input wire logic share_phase_i,
  input wire logic [4:0] own_rail_id_i,
  input wire logic [DELAY_W-1:0] on_delay_i,
  input wire logic [DELAY_W-1:0] off_delay_i,
  // Group bus receive
  input wire logic rx_valid_i,
  input wire logic [2:0] rx_kind_i,
  input wire logic [4:0] rx_id_i,
  input wire logic rx_data_i,
  // Group bus transmit
  output logic tx_valid_o,
  output logic [2:0] tx_kind_o,
  output logic [4:0] tx_id_o,
  input wire logic tx_ready_i,
  input wire logic tx_fail_i,
  input wire logic tx_vset_i,
  input wire logic tx_oper_i,
  // Power stage controls
  input wire logic vout_good_i,
  output logic out_en_o,
  output logic vset_apply_o,
  output logic loop_en_o,
  output logic [7:0] residual_factor_o,
  output logic [15:0] gain_factor_o,
  output logic track_en_o,
  output logic track_half_o,
  output logic track_limit_pin_o
);

////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [31:0] loop;
    logic [15:0] order;
    logic [7:0] track;
    logic [31:0] group;
    rail_seq_pkg::seq_state_t st;
    logic [DELAY_W-1:0] cnt;
    logic oper_en;
    logic pre_seen;
    logic pgood_sent;
    logic [31:0] rdata;
    logic ack;
    logic hit;
    logic tx_v;
    logic [2:0] tx_k;
    logic [4:0] tx_id;
    logic vset;
  } state_t;

  state_t r_reg;
  state_t r_next;
  group_event_if ev();

  assign ev.valid = rx_valid_i;
  assign ev.kind = rail_seq_pkg::event_kind_t'(rx_kind_i);
  assign ev.id = rx_id_i;

  group_event_match u_match (
    .order_i(r_reg.order),
    .group_i(r_reg.group),
    .share_phase_i(share_phase_i),
    .oper_data_i(rx_data_i),
    .ev(ev)
  );

////////////////////////////////////////////////////////////////////////////
  logic en_state;
  logic pre_ok;
  logic tx_busy;
  assign en_state = ctrl_en_i && r_reg.oper_en;
  // No predecessor configured means nothing to wait for
  assign pre_ok = !r_reg.order[rail_seq_pkg::PRE_EN_BIT] ||
    r_reg.pre_seen || ev.pgood_pre; // [R5]
  assign tx_busy = r_reg.tx_v && !tx_ready_i;

  always_comb begin
    r_next = r_reg;
    r_next.ack = 1'b0;
    r_next.hit = 1'b0;
    r_next.vset = 1'b0;
    if (r_reg.tx_v && tx_ready_i) begin
      r_next.tx_v = 1'b0;
    end
    // Command writes and reads; unknown codes answer with hit low
    if (cmd_wr_i) begin
      r_next.ack = 1'b1;
      r_next.hit = 1'b1;
      case (cmd_code_i)
        rail_seq_pkg::LOOP_RESP_OFS:
          r_next.loop = cmd_wdata_i & rail_seq_pkg::LOOP_WMASK; // [R7]
        rail_seq_pkg::RAIL_ORDER_OFS:
          r_next.order = cmd_wdata_i[15:0] & rail_seq_pkg::ORDER_WMASK;
        rail_seq_pkg::TRACK_OFS:
          r_next.track = cmd_wdata_i[7:0] & rail_seq_pkg::TRACK_WMASK;
        rail_seq_pkg::GROUP_OFS:
          r_next.group = cmd_wdata_i & rail_seq_pkg::GROUP_WMASK;
        default: r_next.hit = 1'b0;
      endcase
    end else if (cmd_code_i != 8'h00) begin
      r_next.hit = 1'b1;
      case (cmd_code_i)
        rail_seq_pkg::LOOP_RESP_OFS: r_next.rdata = r_reg.loop;
        rail_seq_pkg::RAIL_ORDER_OFS: r_next.rdata = {16'h0000, r_reg.order};
        rail_seq_pkg::TRACK_OFS: r_next.rdata = {24'h000000, r_reg.track};
        rail_seq_pkg::GROUP_OFS: r_next.rdata = r_reg.group;
        default: begin
          r_next.rdata = 32'h0000_0000;
          r_next.hit = 1'b0;
        end
      endcase
    end
    if (ev.oper_hit) begin
      r_next.oper_en = ev.oper_on; // [R14]
    end
    r_next.vset = ev.vset_hit; // [R12]
    // Host-triggered broadcasts carry the group ids
    if (!tx_busy && !r_reg.tx_v) begin
      if (tx_fail_i) begin
        r_next.tx_v = 1'b1;
        r_next.tx_k = rail_seq_pkg::EV_POWER_FAIL;
        r_next.tx_id = r_reg.group[rail_seq_pkg::PFAIL_ID_LSB +: 5]; // [R15]
      end else if (tx_oper_i) begin
        r_next.tx_v = 1'b1;
        r_next.tx_k = rail_seq_pkg::EV_OPERATION;
        r_next.tx_id = r_reg.group[rail_seq_pkg::OPER_ID_LSB +: 5]; // [R13]
      end else if (tx_vset_i) begin
        r_next.tx_v = 1'b1;
        r_next.tx_k = rail_seq_pkg::EV_VSETPOINT;
        r_next.tx_id = r_reg.group[rail_seq_pkg::VSET_ID_LSB +: 5]; // [R11]
      end else if (r_reg.st == rail_seq_pkg::ST_ON && vout_good_i &&
          !r_reg.pgood_sent) begin
        r_next.tx_v = 1'b1;
        r_next.tx_k = rail_seq_pkg::EV_POWER_GOOD;
        r_next.tx_id = own_rail_id_i; // [R19]
        r_next.pgood_sent = 1'b1;
      end
    end
    case (r_reg.st)
      rail_seq_pkg::ST_OFF: begin
        r_next.pgood_sent = 1'b0;
        if (en_state) begin
          r_next.st = rail_seq_pkg::ST_WAIT_PRE;
        end
      end
      rail_seq_pkg::ST_WAIT_PRE: begin
        if (!en_state) begin
          r_next.st = rail_seq_pkg::ST_OFF;
        end else if (pre_ok) begin
          r_next.st = rail_seq_pkg::ST_ON; // [R1]
        end
      end
      rail_seq_pkg::ST_ON: begin
        if (ev.pfail_imm) begin
          r_next.st = rail_seq_pkg::ST_OFF; // [R16]
          r_next.pre_seen = 1'b0;
        end else if (ev.pdown_fol || ev.pfail_seq || (!en_state &&
            !r_reg.order[rail_seq_pkg::FOL_EN_BIT])) begin
          r_next.st = rail_seq_pkg::ST_STOP_DLY; // [R2]
          r_next.cnt = off_delay_i;
        end
      end
      rail_seq_pkg::ST_STOP_DLY: begin
        // Expired count waits for a free transmitter so power-down is
        // lost only when an immediate power fail ends the delay; a stalled bus keeps the rail on meanwhile
        if (ev.pfail_imm || (r_reg.cnt == '0 && !r_next.tx_v)) begin
          r_next.st = rail_seq_pkg::ST_OFF; // [R2]
          r_next.pre_seen = 1'b0;
          if (!r_next.tx_v) begin
            r_next.tx_v = 1'b1;
            r_next.tx_k = rail_seq_pkg::EV_POWER_DOWN;
            r_next.tx_id = own_rail_id_i; // [R19]
          end
        end else if (r_reg.cnt != '0) begin
          r_next.cnt = r_reg.cnt - 1'b1;
        end
      end
      default: r_next.st = rail_seq_pkg::ST_OFF;
    endcase
    // After the case: a power-good seen while shutting down is kept
    if (ev.pgood_pre) begin
      r_next.pre_seen = 1'b1;
    end
    if (srst_i) begin
      r_next = '0;
      r_next.loop = rail_seq_pkg::LOOP_RESP_RST;
      r_next.order = rail_seq_pkg::RAIL_ORDER_RST;
      r_next.track = rail_seq_pkg::TRACK_RST;
      r_next.group = rail_seq_pkg::GROUP_RST;
      r_next.st = rail_seq_pkg::ST_OFF;
      r_next.oper_en = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    r_reg <= r_next;
  end

////////////////////////////////////////////////////////////////////////////
  assign cmd_rdata_o = r_reg.rdata;
  assign cmd_ack_o = r_reg.ack;
  assign cmd_hit_o = r_reg.hit;
  assign tx_valid_o = r_reg.tx_v;
  assign tx_kind_o = r_reg.tx_k;
  assign tx_id_o = r_reg.tx_id;
  assign out_en_o = r_reg.st == rail_seq_pkg::ST_ON ||
    r_reg.st == rail_seq_pkg::ST_STOP_DLY; // [R1]
  assign vset_apply_o = r_reg.vset;
  assign loop_en_o = r_reg.loop[rail_seq_pkg::LOOP_EN_BIT]; // [R7]
  assign residual_factor_o = r_reg.loop[rail_seq_pkg::RESID_LSB +: 8]; // [R7]
  assign gain_factor_o = r_reg.loop[rail_seq_pkg::GAIN_LSB +: 16]; // [R7]
  assign track_en_o = r_reg.track[rail_seq_pkg::TRK_EN_BIT]; // [R8]
  assign track_half_o = r_reg.track[rail_seq_pkg::TRK_RATIO_BIT]; // [R9]
  assign track_limit_pin_o = r_reg.track[rail_seq_pkg::TRK_LIMIT_BIT]; // [R10]
  // on_delay_i is reserved for the soft-start ramp outside this block
  logic unused_on;
  assign unused_on = |on_delay_i;
endmodule // rail_sequence_group_control

// ===== rsgc_props.sv
// Checker of the command port, setting outputs and group bus transmit.
// Sees only the top module's ports; bound to every instance at the foot.
`timescale 1ns/1ps
module rsgc_props (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic cmd_wr_i,
  input wire logic [31:0] cmd_wdata_i,
  input wire logic [31:0] cmd_rdata_o,
  input wire logic cmd_ack_o,
  input wire logic cmd_hit_o,
  input wire logic rx_valid_i,
  input wire logic [2:0] rx_kind_i,
  input wire logic tx_valid_o,
  input wire logic [2:0] tx_kind_o,
  input wire logic [4:0] tx_id_o,
  input wire logic tx_ready_i,
  input wire logic out_en_o,
  input wire logic vset_apply_o,
  input wire logic loop_en_o,
  input wire logic [7:0] residual_factor_o,
  input wire logic [15:0] gain_factor_o,
  input wire logic track_en_o,
  input wire logic track_half_o,
  input wire logic track_limit_pin_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  wire logic mapped = cmd_code_i >= rail_seq_pkg::LOOP_RESP_OFS &&
    cmd_code_i <= rail_seq_pkg::GROUP_OFS;
  wire logic unmapped = cmd_code_i != 8'h00 && !mapped;
  //////////////////////////////////////////////////////////////////////////
  a_write_ack: assert property (cmd_wr_i |=> cmd_ack_o)
    else $error("write not acknowledged");
  a_hit_mapped: assert property (mapped |=> cmd_hit_o)
    else $error("mapped code not flagged");
  a_hit_unmapped: assert property (unmapped |=> !cmd_hit_o)
    else $error("unmapped code flagged");
  a_read_unmapped: assert property (unmapped && !cmd_wr_i |=> !cmd_rdata_o)
    else $error("unmapped read not zero");
  a_loop_fields: assert property (
    cmd_wr_i && cmd_code_i == rail_seq_pkg::LOOP_RESP_OFS |=>
    {loop_en_o, residual_factor_o, gain_factor_o} ==
    $past(cmd_wdata_i[24:0]))
    else $error("loop fields wrong");
  a_track_fields: assert property (
    cmd_wr_i && cmd_code_i == rail_seq_pkg::TRACK_OFS |=> {track_en_o,
    track_half_o,
    track_limit_pin_o} == {$past(cmd_wdata_i[7]), $past(cmd_wdata_i[2:1])})
    else $error("tracking fields wrong");
  a_vset_cause: assert property (
    vset_apply_o |-> $past(rx_valid_i) &&
    $past(rx_kind_i) == rail_seq_pkg::EV_VSETPOINT)
    else $error("setpoint apply without event");
  a_tx_hold: assert property (
    tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable({tx_kind_o, tx_id_o}))
    else $error("transmit event dropped");
  c_write: cover property (cmd_wr_i ##1 cmd_ack_o);
  c_rise: cover property ($rose(out_en_o));
  c_fall: cover property ($fell(out_en_o));
  c_vset: cover property (vset_apply_o);
endmodule // rsgc_props
bind rail_sequence_group_control rsgc_props u_props (
  .sys_clk_i(sys_clk_i),
  .srst_i(srst_i),
  .cmd_code_i(cmd_code_i),
  .cmd_wr_i(cmd_wr_i),
  .cmd_wdata_i(cmd_wdata_i),
  .cmd_rdata_o(cmd_rdata_o),
  .cmd_ack_o(cmd_ack_o),
  .cmd_hit_o(cmd_hit_o),
  .rx_valid_i(rx_valid_i),
  .rx_kind_i(rx_kind_i),
  .tx_valid_o(tx_valid_o),
  .tx_kind_o(tx_kind_o),
  .tx_id_o(tx_id_o),
  .tx_ready_i(tx_ready_i),
  .out_en_o(out_en_o),
  .vset_apply_o(vset_apply_o),
  .loop_en_o(loop_en_o),
  .residual_factor_o(residual_factor_o),
  .gain_factor_o(gain_factor_o),
  .track_en_o(track_en_o),
  .track_half_o(track_half_o),
  .track_limit_pin_o(track_limit_pin_o)
);

// ===== group_bus_peer.sv
// Neighbouring converter on the group bus: takes our events, sends its own.
// Assumes one shared clock; stall_i holds off acceptance.
`timescale 1ns/1ps
module group_bus_peer (
  input wire logic clk_i,
  input wire logic stall_i,
  input wire logic tx_valid_i,
  input wire logic [2:0] tx_kind_i,
  input wire logic [4:0] tx_id_i,
  output logic tx_ready_o,
  output logic rx_valid_o,
  output logic [2:0] rx_kind_o,
  output logic [4:0] rx_id_o,
  output logic rx_data_o,
  output logic [7:0] seen_o,
  output int seen_cnt_o
);
  assign tx_ready_o = tx_valid_i && !stall_i;
  initial begin
    rx_valid_o = 1'b0;
    rx_kind_o = 3'h7;
    rx_id_o = 5'h1f;
    rx_data_o = 1'b0;
    seen_o = 8'h00;
    seen_cnt_o = 0;
  end
  // Records each event of the rail we sequence against
  always @(posedge clk_i) begin
    if (tx_valid_i && tx_ready_o) begin
      seen_o <= {tx_kind_i, tx_id_i};
      seen_cnt_o <= seen_cnt_o + 1;
    end
  end
  // Idle fields show the inverse so a stale value cannot match
  task automatic send(input logic [2:0] k, input logic [4:0] id,
      input logic d = 1'b0);
    @(posedge clk_i);
    rx_valid_o <= 1'b1;
    rx_kind_o <= k;
    rx_id_o <= id;
    rx_data_o <= d;
    @(posedge clk_i);
    rx_valid_o <= 1'b0;
    rx_kind_o <= ~k;
    rx_id_o <= ~id;
    rx_data_o <= ~d;
  endtask
endmodule // group_bus_peer

// ===== rail_sequence_group_control_tb_top.sv
// Bench: register access, broadcast requests and rail sequencing.
// Assumes the peer model on the group bus and an off delay count of 4, which holds the stop delay for 5 cycles.
`timescale 1ns/1ps
module rail_sequence_group_control_tb_top;
  logic sys_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [7:0] code = 8'h00;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic ctrl_en = 1'b0;
  logic share = 1'b0;
  logic stall = 1'b0;
  logic vgood = 1'b0;
  logic [2:0] req = 3'h0;
  logic [31:0] rdata;
  logic [2:0] rx_kind, tx_kind;
  logic [4:0] rx_id, tx_id;
  logic rx_valid, rx_data, tx_valid, tx_ready, out_en, vset;
  logic [7:0] seen;
  int seen_cnt, n0, mismatches = 0, checks = 0;
  logic [7:0] codes [4] = '{8'hdf, 8'he0, 8'he1, 8'he2};
  logic [31:0] fulls [4] = '{32'h01ff_ffff, 32'h9f9f, 32'h86, 32'h3f_3f3f};
  always #12.5 sys_clk_i = ~sys_clk_i;
  rail_sequence_group_control dut (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
    .cmd_code_i(code), .cmd_wr_i(wr), .cmd_wdata_i(wdata),
    .cmd_rdata_o(rdata), .cmd_ack_o(), .cmd_hit_o(), .ctrl_en_i(ctrl_en),
    .share_phase_i(share), .own_rail_id_i(5'h05), .on_delay_i(16'h0002),
    .off_delay_i(16'h0004), .rx_valid_i(rx_valid), .rx_kind_i(rx_kind),
    .rx_id_i(rx_id), .rx_data_i(rx_data), .tx_valid_o(tx_valid),
    .tx_kind_o(tx_kind), .tx_id_o(tx_id), .tx_ready_i(tx_ready),
    .tx_fail_i(req[0]), .tx_oper_i(req[1]), .tx_vset_i(req[2]),
    .vout_good_i(vgood), .out_en_o(out_en), .vset_apply_o(vset),
    .loop_en_o(), .residual_factor_o(), .gain_factor_o(), .track_en_o(),
    .track_half_o(), .track_limit_pin_o());
  group_bus_peer peer (.clk_i(sys_clk_i), .stall_i(stall),
    .tx_valid_i(tx_valid), .tx_kind_i(tx_kind), .tx_id_i(tx_id),
    .tx_ready_o(tx_ready), .rx_valid_o(rx_valid), .rx_kind_o(rx_kind),
    .rx_id_o(rx_id), .rx_data_o(rx_data), .seen_o(seen),
    .seen_cnt_o(seen_cnt));
  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] c, input logic [31:0] d);
    @(posedge sys_clk_i);
    code <= c;
    wr <= 1'b1;
    wdata <= d;
    @(posedge sys_clk_i);
    wr <= 1'b0;
    code <= 8'h00;
  endtask
  task automatic rreg(input logic [7:0] c, input logic [31:0] e);
    @(posedge sys_clk_i);
    code <= c;
    @(posedge sys_clk_i);
    code <= 8'h00;
    #1 check(rdata, e);
  endtask
  // Bounded waits: an expired bound ends the run
  task automatic wait_out(input logic lvl);
    for (int i = 0; i < 40 && out_en !== lvl; i++) @(posedge sys_clk_i);
    if (out_en !== lvl) begin
      mismatches++;
      finish_test();
    end
  endtask
  task automatic wait_tx();
    for (int i = 0; i < 40 && seen_cnt == n0; i++) @(posedge sys_clk_i);
    #1 check(32'(seen_cnt != n0), 32'h1);
    if (seen_cnt == n0) finish_test();
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    foreach (codes[i]) rreg(codes[i], 32'h0);
    foreach (codes[i]) wreg(codes[i], 32'hffff_ffff);
    foreach (codes[i]) rreg(codes[i], fulls[i]);
    rreg(8'he3, 32'h0);
    wreg(8'hdf, 32'h01a5_1234);
    wreg(8'he1, 32'h84);
    wreg(8'he1, 32'h82);
    wreg(8'he2, 32'h0026_2422);
    // Peer stalls each broadcast for a few cycles before taking it
    for (int i = 0; i < 3; i++) begin
      n0 = seen_cnt;
      stall <= 1'b1;
      req <= 3'(1 << i);
      @(posedge sys_clk_i) req <= 3'h0;
      repeat (3) @(posedge sys_clk_i);
      #1 check(32'(tx_valid), 32'h1);
      stall <= 1'b0;
      wait_tx();
      check(32'(seen), 32'({3'(2 + i), 5'(2 * i + 2)}));
    end
    wreg(8'he0, 32'h8389);
    ctrl_en <= 1'b1;
    peer.send(3'h0, 5'h04);
    repeat (4) @(posedge sys_clk_i);
    #1 check(32'(out_en), 32'h0);
    peer.send(3'h0, 5'h03);
    wait_out(1'b1);
    n0 = seen_cnt;
    vgood <= 1'b1;
    wait_tx();
    check(32'(seen), 32'h05);
    peer.send(3'h1, 5'h08);
    peer.send(3'h3, 5'h05);
    peer.send(3'h4, 5'h06);
    #1 check(32'(vset), 32'h1);
    peer.send(3'h4, 5'h07);
    #1 check(32'(vset), 32'h0);
    repeat (2) @(posedge sys_clk_i);
    #1 check(32'(out_en), 32'h1);
    n0 = seen_cnt;
    peer.send(3'h1, 5'h09);
    repeat (2) @(posedge sys_clk_i);
    #1 check(32'(out_en), 32'h1);
    wait_out(1'b0);
    wait_tx();
    check(32'(seen), 32'h25);
    vgood <= 1'b0;
    wreg(8'he0, 32'h0);
    wait_out(1'b1);
    peer.send(3'h3, 5'h04, 1'b0);
    wait_out(1'b0);
    peer.send(3'h3, 5'h04, 1'b1);
    wait_out(1'b1);
    peer.send(3'h2, 5'h02);
    #1 check(32'(out_en), 32'h0);
    ctrl_en <= 1'b0;
    wreg(8'he2, 32'h0026_2402);
    ctrl_en <= 1'b1;
    wait_out(1'b1);
    peer.send(3'h2, 5'h1e);
    repeat (8) @(posedge sys_clk_i);
    #1 check(32'(out_en), 32'h1);
    peer.send(3'h2, 5'h02);
    #1 check(32'(out_en), 32'h1);
    wait_out(1'b0);
    wait_out(1'b1);
    share <= 1'b1;
    peer.send(3'h2, 5'h1e);
    wait_out(1'b0);
    // Mid-run reset must bring the group setting back to zero
    srst_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    rreg(8'he2, 32'h0);
    finish_test();
  end
endmodule // rail_sequence_group_control_tb_top
